// ### hsr_host_front.sv
// Host mode front end: register slave, reset char, run command, requests
`timescale 1ns/1ps
module hsr_host_front
  import hsr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic poll_done,
  output logic poll_req,
  output logic [7:0] poll_byte,
  input wire logic run_done,
  output logic run_start,
  output logic run_task2,
  output logic [15:0] run_prog,
  output logic host_mode
);

  typedef enum logic [2:0] {
    P_IDLE = 3'b000, P_CMD = 3'b001, P_TASK = 3'b010, P_MODE = 3'b011,
    P_NUM = 3'b100, P_SKIP = 3'b101
  } hsr_parse_e;

  function automatic logic hsr_is_err(input logic [7:0] c);
    return c == HSR_CODE_CMD_ERR || c == HSR_CODE_MEM_ERR;
  endfunction

  function automatic logic hsr_is_digit(input logic [7:0] c);
    return c >= HSR_CH_0 && c <= HSR_CH_9;
  endfunction

  // ****************************************
  // Registers and next values
  // ****************************************
  logic [3:0] ctrl_ff, nxt_ctrl;
  logic [7:0] rst_ch_ff, nxt_rst_ch, req_ch_ff, nxt_req_ch;
  logic [7:0] ack_ch_ff, nxt_ack_ch;
  logic host_ff, nxt_host;
  logic pend_ff, nxt_pend, pend_err_ff, nxt_pend_err;
  logic [7:0] pend_code_ff, nxt_pend_code, pend_ecode_ff, nxt_pend_ecode;
  logic [7:0] last_code_ff, nxt_last_code, last_err_ff, nxt_last_err;
  hsr_parse_e p_ff, nxt_p;
  logic [7:0] perr_ff, nxt_perr;
  logic digits_ff, nxt_digits, defer_ff, nxt_defer;
  logic nxt_run_start, nxt_run_task2;
  logic [15:0] nxt_run_prog;
  logic nxt_ack;
  logic [31:0] nxt_dat;

  logic ieee, wr, rd, svc_busy, svc_wait, ack_hit, cmd_ch, reset_hit;
  logic post_v, post_err, start, any_v, any_err;
  logic [7:0] post_code, post_ecode, any_code, any_ecode;

  assign ieee = ctrl_ff[HSR_CTRL_IEEE];
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign ack_hit = rx_valid & svc_wait & (rx_data == ack_ch_ff);
  assign reset_hit = rx_valid & ~ieee & (rx_data == rst_ch_ff)
                     & (rx_data != ack_ch_ff);
  // Acks never reach the parser; stalled while a request is open
  assign cmd_ch = rx_valid & (rx_data != ack_ch_ff) & ~reset_hit
                  & (ieee | host_ff) & ~svc_busy & ~pend_ff & ~defer_ff;
  assign start = pend_ff & ~svc_busy;

  // ****************************************
  // Command parser
  // ****************************************
  always_comb begin
    nxt_p = p_ff;
    nxt_perr = perr_ff;
    nxt_digits = digits_ff;
    nxt_defer = defer_ff & ~run_done;
    nxt_run_start = 1'b0;
    nxt_run_task2 = run_task2;
    nxt_run_prog = run_prog;
    post_v = 1'b0;
    post_err = 1'b0;
    post_code = HSR_CODE_READY;
    post_ecode = 8'h00;
    if (reset_hit) begin
      nxt_p = P_IDLE;
      post_v = 1'b1;
    end else if (defer_ff && run_done) begin
      post_v = 1'b1;
    end else if (cmd_ch) begin
      unique case (p_ff)
        P_IDLE: nxt_p = (rx_data == HSR_CH_HASH) ? P_CMD : P_IDLE;
        P_CMD: begin
          nxt_p = (rx_data == HSR_CH_B) ? P_TASK : P_SKIP;
          nxt_perr = HSR_ERR_SYNTAX;
        end
        P_TASK: begin
          nxt_p = P_SKIP;
          if (rx_data == HSR_CH_A || rx_data == HSR_CH_B) begin
            nxt_run_task2 = (rx_data == HSR_CH_B);
            nxt_p = P_MODE;
          end
        end
        P_MODE: begin
          nxt_p = P_SKIP;
          nxt_digits = 1'b0;
          nxt_run_prog = 16'h0000;
          if (rx_data == HSR_CH_A) begin
            nxt_p = P_NUM;
          end else if (rx_data == HSR_CH_B) begin
            nxt_perr = HSR_ERR_BLOCK;
          end
        end
        P_NUM: begin
          if (hsr_is_digit(rx_data)) begin
            nxt_digits = 1'b1;
            nxt_run_prog = 16'(run_prog * 16'd10 + 16'(rx_data - HSR_CH_0));
          end else if (rx_data == HSR_CH_LF && digits_ff) begin
            nxt_p = P_IDLE;
            nxt_run_start = 1'b1;
            if (ctrl_ff[HSR_CTRL_TIMA] && ctrl_ff[HSR_CTRL_TIMB]) begin
              nxt_defer = 1'b1;
            end else begin
              post_v = 1'b1;
            end
          end else begin
            nxt_p = (rx_data == HSR_CH_LF) ? P_IDLE : P_SKIP;
            post_v = (rx_data == HSR_CH_LF);
            post_err = 1'b1;
            post_code = HSR_CODE_CMD_ERR;
            post_ecode = HSR_ERR_SYNTAX;
          end
        end
        P_SKIP: begin
          if (rx_data == HSR_CH_LF) begin
            nxt_p = P_IDLE;
            post_v = 1'b1;
            post_err = 1'b1;
            post_code = HSR_CODE_CMD_ERR;
            post_ecode = perr_ff;
          end
        end
        default: nxt_p = P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      p_ff <= P_IDLE;
      perr_ff <= 8'h00;
      digits_ff <= 1'b0;
      defer_ff <= 1'b0;
      run_start <= 1'b0;
      run_task2 <= 1'b0;
      run_prog <= 16'h0000;
    end else begin
      p_ff <= nxt_p;
      perr_ff <= nxt_perr;
      digits_ff <= nxt_digits;
      defer_ff <= nxt_defer;
      run_start <= nxt_run_start;
      run_task2 <= nxt_run_task2;
      run_prog <= nxt_run_prog;
    end
  end

  // ****************************************
  // Register slave and pending request
  // ****************************************
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rst_ch = rst_ch_ff;
    nxt_req_ch = req_ch_ff;
    nxt_ack_ch = ack_ch_ff;
    nxt_host = host_ff | reset_hit | ieee;
    nxt_pend = pend_ff & svc_busy;
    nxt_pend_code = pend_code_ff;
    nxt_pend_err = pend_err_ff;
    nxt_pend_ecode = pend_ecode_ff;
    nxt_last_code = start ? pend_code_ff : last_code_ff;
    nxt_last_err = last_err_ff;
    nxt_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    nxt_dat = 32'h0000_0000;
    any_v = post_v;
    any_err = post_err;
    any_code = post_code;
    any_ecode = post_ecode;
    // Hardware posts win over software posts in the same cycle
    if (!post_v && wr && wb_sel_i[0]) begin
      if (wb_adr_i == HSR_OFS_EVENT) begin
        any_v = 1'b1;
        any_code = wb_dat_i[7:0];
        any_err = hsr_is_err(wb_dat_i[7:0]);
        any_ecode = wb_dat_i[15:8];
      end else if (wb_adr_i == HSR_OFS_USER && wb_dat_i[3:0] != 4'h0) begin
        any_v = 1'b1;
        any_code = (wb_dat_i[HSR_USER_TASK2] ? HSR_CODE_USER_T2
                    : HSR_CODE_USER_T1) | {4'h0, wb_dat_i[3:0]};
      end
    end
    if (any_v && !pend_ff
        && (any_err || (ieee ? (any_code == HSR_CODE_UPLOAD
                                || any_code == HSR_CODE_DOWNLOAD)
                             : ctrl_ff[HSR_CTRL_REQEN]))) begin
      nxt_pend = 1'b1;
      nxt_pend_code = any_code;
      nxt_pend_err = any_err;
      nxt_pend_ecode = any_ecode;
      nxt_last_err = any_err ? any_ecode : last_err_ff;
    end
    if (wr && wb_adr_i == HSR_OFS_CTRL && wb_sel_i[0]) begin
      nxt_ctrl = wb_dat_i[3:0];
    end
    if (wr && wb_adr_i == HSR_OFS_CHARS) begin
      nxt_rst_ch = wb_sel_i[0] ? wb_dat_i[7:0] : rst_ch_ff;
      nxt_req_ch = wb_sel_i[1] ? wb_dat_i[15:8] : req_ch_ff;
      nxt_ack_ch = wb_sel_i[2] ? wb_dat_i[23:16] : ack_ch_ff;
    end
    if (rd) begin
      unique case (wb_adr_i)
        HSR_OFS_CTRL: nxt_dat = {28'h000_0000, ctrl_ff};
        HSR_OFS_CHARS: nxt_dat = {8'h00, ack_ch_ff, req_ch_ff, rst_ch_ff};
        HSR_OFS_STATUS: nxt_dat = {8'h00, last_err_ff, last_code_ff,
          4'h0, defer_ff, svc_busy, pend_ff, host_ff};
        HSR_OFS_RUN: nxt_dat = {15'h0000, run_task2, run_prog};
        default: nxt_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_ff <= HSR_CTRL_RST;
      rst_ch_ff <= HSR_RESET_CHAR_RST;
      req_ch_ff <= HSR_REQ_CHAR_RST;
      ack_ch_ff <= HSR_ACK_CHAR_RST;
      host_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_code_ff <= 8'h00;
      pend_err_ff <= 1'b0;
      pend_ecode_ff <= 8'h00;
      last_code_ff <= 8'h00;
      last_err_ff <= 8'h00;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      host_mode <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rst_ch_ff <= nxt_rst_ch;
      req_ch_ff <= nxt_req_ch;
      ack_ch_ff <= nxt_ack_ch;
      host_ff <= nxt_host;
      pend_ff <= nxt_pend;
      pend_code_ff <= nxt_pend_code;
      pend_err_ff <= nxt_pend_err;
      pend_ecode_ff <= nxt_pend_ecode;
      last_code_ff <= nxt_last_code;
      last_err_ff <= nxt_last_err;
      wb_ack_o <= nxt_ack;
      wb_dat_o <= nxt_dat;
      host_mode <= nxt_host;
    end
  end

  hsr_svc_tx u_svc (
    .clk(clk),
    .nrst(nrst),
    .start(start),
    .code(pend_code_ff),
    .is_err(pend_err_ff),
    .err_code(pend_ecode_ff),
    .ieee(ieee),
    .req_char(req_ch_ff),
    .ack_hit(ack_hit),
    .poll_done(poll_done),
    .tx_ready(tx_ready),
    .busy(svc_busy),
    .waiting(svc_wait),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .poll_req(poll_req),
    .poll_byte(poll_byte)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_ieee_host;
    ieee |=> host_mode;
  endproperty
  a_ieee_host: assert property (p_ieee_host)
    else $error("parallel link without host mode");

  property p_suppress;
    $rose(pend_ff) && !pend_err_ff && !$past(ieee) |->
      $past(ctrl_ff[HSR_CTRL_REQEN]);
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("plain request posted while requests disabled");

  property p_ieee_filter;
    $rose(pend_ff) && $past(ieee) |-> pend_err_ff
      || pend_code_ff == HSR_CODE_UPLOAD || pend_code_ff == HSR_CODE_DOWNLOAD;
  endproperty
  a_ieee_filter: assert property (p_ieee_filter)
    else $error("non transfer request on parallel link");

  property p_stray_ack;
    rx_valid && rx_data == ack_ch_ff && !svc_wait |=>
      $stable(p_ff) && $stable(pend_ff) && $stable(run_prog);
  endproperty
  a_stray_ack: assert property (p_stray_ack)
    else $error("stray ack changed state");

  property p_block_refused;
    cmd_ch && p_ff == P_MODE && rx_data == HSR_CH_B |=>
      p_ff == P_SKIP && perr_ff == HSR_ERR_BLOCK && !run_start;
  endproperty
  a_block_refused: assert property (p_block_refused)
    else $error("block run mode not refused");

  property p_ready_after_reset;
    reset_hit && !pend_ff && ctrl_ff[HSR_CTRL_REQEN] |=>
      pend_ff && pend_code_ff == HSR_CODE_READY && host_mode;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset)
    else $error("no ready request after host reset");

  property p_user_code;
    wr && !post_v && wb_adr_i == HSR_OFS_USER && !pend_ff && wb_sel_i[0]
      && wb_dat_i[3:0] != 4'h0 && !ieee && ctrl_ff[HSR_CTRL_REQEN] |=>
      pend_code_ff[3:0] == $past(wb_dat_i[3:0]) && pend_code_ff[7:6] == 2'b00;
  endproperty
  a_user_code: assert property (p_user_code)
    else $error("user request code mismatch");

  property p_run_cmd;
    run_start |-> $past(p_ff == P_NUM && rx_data == HSR_CH_LF && cmd_ch);
  endproperty
  a_run_cmd: assert property (p_run_cmd)
    else $error("run started without a complete command");

endmodule

// ### hsr_pkg.sv
// Constants shared by the host service request front end
package hsr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] HSR_OFS_CTRL = 8'h00;
  localparam logic [7:0] HSR_OFS_CHARS = 8'h04;
  localparam logic [7:0] HSR_OFS_EVENT = 8'h08;
  localparam logic [7:0] HSR_OFS_USER = 8'h0c;
  localparam logic [7:0] HSR_OFS_STATUS = 8'h10;
  localparam logic [7:0] HSR_OFS_RUN = 8'h14;

  localparam int HSR_CTRL_IEEE = 0;
  localparam int HSR_CTRL_REQEN = 1;
  localparam int HSR_CTRL_TIMA = 2;
  localparam int HSR_CTRL_TIMB = 3;
  localparam int HSR_USER_TASK2 = 8;
  localparam int HSR_RQS_BIT = 6;

  localparam logic [3:0] HSR_CTRL_RST = 4'h2;
  localparam logic [7:0] HSR_RESET_CHAR_RST = 8'h1b;
  localparam logic [7:0] HSR_REQ_CHAR_RST = 8'h05;
  localparam logic [7:0] HSR_ACK_CHAR_RST = 8'h06;

  // ****************************************
  // Status codes
  // ****************************************
  localparam logic [7:0] HSR_CODE_UPLOAD = 8'h01;
  localparam logic [7:0] HSR_CODE_DOWNLOAD = 8'h02;
  localparam logic [7:0] HSR_CODE_CMD_ERR = 8'h03;
  localparam logic [7:0] HSR_CODE_MEM_ERR = 8'h04;
  localparam logic [7:0] HSR_CODE_LINE_T1 = 8'h05;
  localparam logic [7:0] HSR_CODE_LINE_T2 = 8'h06;
  localparam logic [7:0] HSR_CODE_READY = 8'h07;
  localparam logic [7:0] HSR_CODE_USER_T1 = 8'h10;
  localparam logic [7:0] HSR_CODE_USER_T2 = 8'h20;
  localparam logic [7:0] HSR_CODE_XON = 8'h31;
  localparam logic [7:0] HSR_CODE_XOFF = 8'h32;
  localparam logic [7:0] HSR_CODE_EXCEPT = 8'h33;

  localparam logic [7:0] HSR_ERR_SYNTAX = 8'h01;
  localparam logic [7:0] HSR_ERR_BLOCK = 8'h02;

  // ****************************************
  // Command characters
  // ****************************************
  localparam logic [7:0] HSR_CH_HASH = 8'h23;
  localparam logic [7:0] HSR_CH_A = 8'h41;
  localparam logic [7:0] HSR_CH_B = 8'h42;
  localparam logic [7:0] HSR_CH_LF = 8'h0a;
  localparam logic [7:0] HSR_CH_0 = 8'h30;
  localparam logic [7:0] HSR_CH_9 = 8'h39;

endpackage

// ### hsr_svc_tx.sv
// Service request sender: character framing, poll wait, ack wait
`timescale 1ns/1ps
module hsr_svc_tx
  import hsr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] code,
  input wire logic is_err,
  input wire logic [7:0] err_code,
  input wire logic ieee,
  input wire logic [7:0] req_char,
  input wire logic ack_hit,
  input wire logic poll_done,
  input wire logic tx_ready,
  output logic busy,
  output logic waiting,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic poll_req,
  output logic [7:0] poll_byte
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_CHAR = 3'b001, S_STAT = 3'b010, S_CMPL = 3'b011,
    S_ERRC = 3'b100, S_WACK = 3'b101, S_POLL = 3'b110
  } hsr_tx_e;

  hsr_tx_e st_ff, nxt_st;
  logic [7:0] code_ff, nxt_code, ecode_ff, nxt_ecode;
  logic err_ff, nxt_err, ieee_ff, nxt_ieee;
  logic nxt_tx_valid, nxt_poll_req;
  logic [7:0] nxt_tx_data, nxt_poll_byte;
  logic sent;

  assign sent = tx_valid & tx_ready;

  always_comb begin
    nxt_st = st_ff;
    nxt_code = code_ff;
    nxt_ecode = ecode_ff;
    nxt_err = err_ff;
    nxt_ieee = ieee_ff;
    nxt_tx_valid = tx_valid & ~tx_ready;
    nxt_tx_data = tx_data;
    nxt_poll_req = poll_req;
    nxt_poll_byte = poll_byte;
    unique case (st_ff)
      S_IDLE: begin
        if (start) begin
          nxt_code = code;
          nxt_ecode = err_code;
          nxt_err = is_err;
          nxt_ieee = ieee;
          if (ieee) begin
            nxt_st = S_POLL;
            nxt_poll_req = 1'b1;
            nxt_poll_byte = code | 8'(1 << HSR_RQS_BIT);
          end else begin
            nxt_st = S_CHAR;
            nxt_tx_valid = 1'b1;
            nxt_tx_data = req_char;
          end
        end
      end
      S_CHAR: begin
        if (sent) begin
          nxt_st = S_STAT;
          nxt_tx_valid = 1'b1;
          nxt_tx_data = code_ff;
        end
      end
      S_STAT: begin
        if (sent) begin
          nxt_st = S_CMPL;
          nxt_tx_valid = 1'b1;
          nxt_tx_data = ~code_ff;
        end
      end
      S_CMPL: begin
        if (sent) begin
          if (err_ff) begin
            nxt_st = S_ERRC;
            nxt_tx_valid = 1'b1;
            nxt_tx_data = ecode_ff;
          end else begin
            nxt_st = S_WACK;
          end
        end
      end
      S_ERRC: begin
        if (sent) begin
          nxt_st = ieee_ff ? S_IDLE : S_WACK;
        end
      end
      S_WACK: begin
        if (ack_hit) begin
          nxt_st = S_IDLE;
        end
      end
      S_POLL: begin
        if (poll_done) begin
          nxt_poll_req = 1'b0;
          if (err_ff) begin
            nxt_st = S_ERRC;
            nxt_tx_valid = 1'b1;
            nxt_tx_data = ecode_ff;
          end else begin
            nxt_st = S_IDLE;
          end
        end
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= S_IDLE;
      code_ff <= 8'h00;
      ecode_ff <= 8'h00;
      err_ff <= 1'b0;
      ieee_ff <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      poll_req <= 1'b0;
      poll_byte <= 8'h00;
      busy <= 1'b0;
      waiting <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      code_ff <= nxt_code;
      ecode_ff <= nxt_ecode;
      err_ff <= nxt_err;
      ieee_ff <= nxt_ieee;
      tx_valid <= nxt_tx_valid;
      tx_data <= nxt_tx_data;
      poll_req <= nxt_poll_req;
      poll_byte <= nxt_poll_byte;
      busy <= (nxt_st != S_IDLE);
      waiting <= (nxt_st == S_WACK);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_char_sent;
    tx_valid && tx_ready && st_ff == S_CHAR;
  endsequence
  sequence s_stat_out;
    tx_valid && tx_data == code_ff;
  endsequence

  property p_frame_order;
    @(posedge clk) disable iff (!nrst)
    s_char_sent |=> s_stat_out;
  endproperty
  a_frame_order: assert property (p_frame_order)
    else $error("status byte did not follow request char");

  property p_complement;
    @(posedge clk) disable iff (!nrst)
    (st_ff == S_STAT && sent) |=> tx_valid && tx_data == ~$past(tx_data);
  endproperty
  a_complement: assert property (p_complement)
    else $error("third byte is not the complement of the status");

  property p_hold_until_ack;
    @(posedge clk) disable iff (!nrst)
    (waiting && !ack_hit) |=> waiting && busy;
  endproperty
  a_hold_until_ack: assert property (p_hold_until_ack)
    else $error("ack wait left without an ack");

  property p_poll_load;
    @(posedge clk) disable iff (!nrst)
    (st_ff == S_IDLE && start && ieee) |=>
      poll_req && poll_byte[5:0] == $past(code[5:0]) && !tx_valid;
  endproperty
  a_poll_load: assert property (p_poll_load)
    else $error("poll byte not loaded with status code");

  property p_err_follows;
    @(posedge clk) disable iff (!nrst)
    (st_ff == S_CMPL && sent && err_ff) |=> tx_valid && tx_data == ecode_ff;
  endproperty
  a_err_follows: assert property (p_err_follows)
    else $error("error code did not follow error request");

endmodule

// ### hsr_host_model.sv
// Host side model: link receiver and serial poller
`timescale 1ns/1ps
module hsr_host_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic poll_req,
  input wire logic [7:0] poll_byte,
  output logic tx_ready,
  output logic poll_done
);
  logic [7:0] got[$];
  logic [1:0] gap = 2'h0;
  initial begin
    tx_ready = 1'b0;
    poll_done = 1'b0;
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
    poll_done <= 1'b0;
    if (gap != 2'h0) gap <= gap - 2'h1;
    if (poll_req && gap == 2'h0 && !poll_done) begin
      got.push_back(poll_byte & 8'hbf);
      poll_done <= 1'b1;
      gap <= 2'h3;
    end
  end
endmodule

// ### hsr_host_front_tb.sv
// Self-checking bench for the host request front end
`timescale 1ns/1ps
module hsr_host_front_tb;
  import hsr_pkg::*;
  logic clk, txr, txv, pd, pq, rs, rt2, hm, ack, rs_t2;
  logic nrst = 0, cyc = 0, stb = 0, we = 0, rxv = 0, rdone = 0, slow = 0;
  logic [7:0] adr = 0, rxd = 0, txd, pb, ec, cd, rc = 8'h05, ac = 8'h06;
  logic [3:0] sel = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [15:0] rp, rs_p;
  logic [7:0] codes[7] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h31, 8'h32, 8'h33};
  int n_fail = 0, tests_run = 0, cyc_n = 0, rs_n = 0;

  hsr_host_front i_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_valid(rxv),
    .rx_data(rxd), .tx_ready(txr), .tx_valid(txv), .tx_data(txd),
    .poll_done(pd), .poll_req(pq), .poll_byte(pb), .run_done(rdone),
    .run_start(rs), .run_task2(rt2), .run_prog(rp), .host_mode(hm));
  hsr_host_model i_host (.clk(clk), .slow(slow), .tx_valid(txv),
    .tx_data(txd), .poll_req(pq), .poll_byte(pb), .tx_ready(txr),
    .poll_done(pd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (rs === 1'b1) begin
      rs_n++;
      rs_t2 = rt2;
      rs_p = rp;
    end
    if (cyc_n == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Bus, link and compare tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic sendc(input logic [7:0] c);
    @(posedge clk);
    rxv <= 1'b1;
    rxd <= c;
    @(posedge clk);
    rxv <= 1'b0;
  endtask
  task automatic sends(input string s);
    for (int i = 0; i < s.len(); i++) sendc(s[i]);
  endtask
  task automatic take(input logic [31:0] e, input int n);
    logic [31:0] g;
    int k;
    g = 0;
    k = 0;
    while (i_host.got.size() < n && k < 500) begin
      @(posedge clk);
      k++;
    end
    foreach (i_host.got[i]) g = {g[23:0], i_host.got[i]};
    chk("bytes", e, g);
    chk("count", 32'(n), 32'(i_host.got.size()));
    i_host.got.delete();
  endtask
  task automatic service_request(input logic [31:0] e, input int n);
    take(e, n);
    sendc(ac);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    void'($urandom(50));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    wb(0, HSR_OFS_CHARS, 0, q);
    chk("chars", 32'h0006_051b, q);
    sends("#BAA1\n");
    repeat (10) @(posedge clk);
    chk("early", 0, {hm, 8'(rs_n), 8'(i_host.got.size())});
    sendc(8'h1b);
    service_request({rc, HSR_CODE_READY, ~HSR_CODE_READY}, 3);
    sendc(ac);
    repeat (10) @(posedge clk);
    wb(0, HSR_OFS_STATUS, 0, q);
    chk("stray", 32'h0100, {q[1:0], 8'(i_host.got.size())});
    rc = 8'h80 | 8'($urandom_range(126));
    ac = rc ^ 8'h01;
    wb(1, HSR_OFS_CHARS, {8'h00, ac, rc, 8'h1b}, q);
    for (int t = 0; t < 2; t++) begin
      cd = 8'($urandom_range(15, 1));
      wb(1, HSR_OFS_USER, {23'h0, t[0], 4'h0, cd[3:0]}, q);
      cd = cd | (t == 1 ? 8'h20 : 8'h10);
      service_request({rc, cd, ~cd}, 3);
    end
    foreach (codes[i]) begin
      wb(1, HSR_OFS_EVENT, {24'h0, codes[i]}, q);
      service_request({rc, codes[i], ~codes[i]}, 3);
    end
    ec = 8'($urandom_range(255, 1));
    wb(1, HSR_OFS_EVENT, {16'h0, ec, HSR_CODE_CMD_ERR}, q);
    service_request({rc, HSR_CODE_CMD_ERR, ~HSR_CODE_CMD_ERR, ec}, 4);
    slow <= 1'b1;
    wb(1, HSR_OFS_CTRL, 0, q);
    wb(1, HSR_OFS_EVENT, {24'h0, HSR_CODE_XON}, q);
    repeat (20) @(posedge clk);
    chk("quiet", 0, 32'(i_host.got.size()));
    wb(1, HSR_OFS_EVENT, {16'h0, ec, HSR_CODE_MEM_ERR}, q);
    service_request({rc, HSR_CODE_MEM_ERR, ~HSR_CODE_MEM_ERR, ec}, 4);
    wb(1, HSR_OFS_CTRL, 32'h2, q);
    cd = 8'($urandom_range(9, 1));
    sends($sformatf("#BBA%0d\n", cd));
    service_request({rc, HSR_CODE_READY, ~HSR_CODE_READY}, 3);
    chk("run", {16'h0101, 8'h0, cd}, {8'(rs_n), 7'h0, rs_t2, rs_p});
    sends("#BAB1\n");
    service_request({rc, HSR_CODE_CMD_ERR, ~HSR_CODE_CMD_ERR, HSR_ERR_BLOCK}, 4);
    chk("runs", 1, 32'(rs_n));
    wb(1, HSR_OFS_CTRL, 32'he, q);
    sends("#BAA3\n");
    repeat (10) @(posedge clk);
    chk("defer", 32'h0200, {8'(rs_n), 8'(i_host.got.size())});
    rdone <= 1'b1;
    @(posedge clk);
    rdone <= 1'b0;
    service_request({rc, HSR_CODE_READY, ~HSR_CODE_READY}, 3);
    slow <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wb(1, HSR_OFS_CTRL, 32'h3, q);
    repeat (2) @(posedge clk);
    chk("ieee", 1, 32'(hm));
    wb(1, HSR_OFS_EVENT, {24'h0, HSR_CODE_XON}, q);
    repeat (20) @(posedge clk);
    chk("ieee_xon", 0, {pq, 8'(i_host.got.size())});
    wb(1, HSR_OFS_EVENT, {16'h0, ec, HSR_CODE_CMD_ERR}, q);
    take({HSR_CODE_CMD_ERR, ec}, 2);
    tally_and_finish();
  end
endmodule
